// [design/pin_group_config_unit.sv]
// Purpose: Direction, sampling and pin function state of one pin group.
// Assumes: Classic Wishbone slave, one clock, synchronous reset.
// Notes:   Answers every access one cycle after the strobe is seen.
//
// The Wishbone register port was decided locally.
`timescale 1ns/10ps

// Function
// - Direction set writes ones, zeros keep.
// - All direction views share one state.
// - Each group decoded at 0x80 spacing.
// - Sampling bit zero on demand, one continuous.
// - Samplers switch per eight-pin lane.
// - Update pin settings loads selected pins.
// - Update function select loads selected pins.
// - Function code taken from bits 27:24.
// - Bits 22,18,17 give drive, pull, input.
// - Atomic config write reads as zero.
// - Every pin function gated by enable.
// - Codes 0x0-0xD legal, 0xE-0xF reserved.
module pin_group_config_unit #(
   parameter int          ADR_W       = 12,  // Byte address width
   parameter int          GROUP_INDEX = 0    // Which 0x80 window
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   input  wire logic              we_i,
   input  wire logic [ADR_W-1:0]  adr_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic [31:0]       dat_i,
   output logic      [31:0]       dat_o,
   output logic                   ack_o,
   output logic      [31:0]       dir_o,         // One means output
   output logic      [3:0]        lane_cont_o,   // Lane sampler always on
   output logic      [31:0]       fen_o,         // function_select_on
   output logic      [31:0]       input_buffer_on_o,        // input_buffer_on
   output logic      [31:0]       pull_o,        // pull_resistor_on
   output logic      [31:0]       drv_o,         // drive_strength
   output logic      [127:0]      func_o,        // Code per pin, 4 bits
   output logic      [31:0]       func_act_o     // Peripheral routed
);

   // Whole state of the block
   typedef struct packed {
      logic [31:0]       dir;      // Direction, shared by four views
      logic [31:0]       ctrl;     // Sampling mode per pin
      logic [3:0]        lane;     // Registered lane enables
      logic [31:0]       fen;
      logic [31:0]       input_buffer_on;
      logic [31:0]       pull;
      logic [31:0]       drv;
      logic [31:0][3:0]  func;     // Function code per pin
      logic [31:0]       act;      // Enabled and legal code
      logic              ack;
      logic [31:0]       rdata;
   } state_t;

   state_t              state_reg;   // Registered state
   state_t              state_next;  // Next state
   logic                hit;         // New access this cycle
   logic                grp_ok;      // Address inside this group
   logic [6:0]          off;         // Offset inside window
   logic [4:0]          off_word;    // Word index inside window
   logic [31:0]         wmask;       // Byte enables as bit mask
   logic [31:0]         wdat;        // Write data under byte enables
   logic [31:0]         pin_sel;     // Pins picked by atomic write

   localparam logic [4:0] FUNCTION_SELECT_W0 = pin_group_pkg::OFF_FUNCTION_SELECT[6:2];
   localparam logic [4:0] PCFG_W0 = pin_group_pkg::OFF_PCFG[6:2];

   // Expand byte enables into a bit mask
   function automatic logic [31:0] byte_mask(input logic [3:0] s);
      logic [31:0] m;
      m = '0;
      for (int b = 0; b < 4; b++) begin
         m[b*8 +: 8] = {8{s[b]}};
      end
      return m;
   endfunction

   // Lane is continuous if any input pin in it asks for it
   function automatic logic [3:0] lane_req(input logic [31:0] c,
                                           input logic [31:0] d);
      logic [3:0]  l;
      logic [31:0] q;
      q = c & ~d;
      for (int k = 0; k < pin_group_pkg::LANE_COUNT; k++) begin
         l[k] = |q[k*pin_group_pkg::LANE_PINS +: pin_group_pkg::LANE_PINS];
      end
      return l;
   endfunction

   // Read view of one register
   function automatic logic [31:0] read_word(input state_t s,
                                             input logic [6:0] o);
      logic [31:0] r;
      logic [4:0]  w;
      r = '0;
      w = o[6:2];
      unique case (o)
         pin_group_pkg::OFF_DIR,
         pin_group_pkg::OFF_DIRECTION_CLEAR,
         pin_group_pkg::OFF_DIRECTION_SET,
         pin_group_pkg::OFF_DIRECTION_TOGGLE: r = s.dir;
         pin_group_pkg::OFF_CTRL:   r = s.ctrl;
         pin_group_pkg::OFF_WRCFG:  r = '0;
         default: begin
            // Pin settings packed four per word, function pairs eight codes per word
            for (int i = 0; i < pin_group_pkg::PIN_COUNT; i++) begin
               if (w == PCFG_W0 + 5'(i / 4)) begin
                  r[(i%4)*8 + pin_group_pkg::PC_FEN]  = s.fen[i];
                  r[(i%4)*8 + pin_group_pkg::PC_INPUT_BUFFER_ON] = s.input_buffer_on[i];
                  r[(i%4)*8 + pin_group_pkg::PC_PULL] = s.pull[i];
                  r[(i%4)*8 + pin_group_pkg::PC_DRV]  = s.drv[i];
               end
               if (w == FUNCTION_SELECT_W0 + 5'(i / 8)) begin
                  r[(i%8)*4 +: 4] = s.func[i];
               end
            end
         end
      endcase
      return r;
   endfunction

   // Address decode and data masking
   assign off      = adr_i[pin_group_pkg::OFF_W-1:0];
   assign off_word = adr_i[pin_group_pkg::OFF_W-1:2];
   assign grp_ok   = (int'(adr_i[ADR_W-1:pin_group_pkg::GROUP_SPAN_LG])
                      == GROUP_INDEX);
   assign hit      = cyc_i && stb_i && !state_reg.ack;
   assign wmask    = byte_mask(sel_i);
   assign wdat     = dat_i & wmask;
   assign pin_sel  = dat_i[pin_group_pkg::WC_HALF_WORD_SELECT]
                   ? {dat_i[pin_group_pkg::WC_MASK_W-1:0], 16'h0000}
                   : {16'h0000, dat_i[pin_group_pkg::WC_MASK_W-1:0]};

   // Next state: bus answer, register writes, derived outputs
   always_comb begin
      state_next       = state_reg;
      state_next.ack   = hit;
      state_next.rdata = '0;
      if (hit && !we_i && grp_ok) begin
         state_next.rdata = read_word(state_reg, off);
      end
      if (hit && we_i && grp_ok) begin
         unique case (off)
            pin_group_pkg::OFF_DIR: begin
               state_next.dir = (state_reg.dir & ~wmask) | wdat;
            end
            pin_group_pkg::OFF_DIRECTION_CLEAR: begin
               state_next.dir = state_reg.dir & ~wdat;
            end
            pin_group_pkg::OFF_DIRECTION_SET: begin
               state_next.dir = state_reg.dir | wdat;
            end
            pin_group_pkg::OFF_DIRECTION_TOGGLE: begin
               state_next.dir = state_reg.dir ^ wdat;
            end
            pin_group_pkg::OFF_CTRL: begin
               state_next.ctrl = (state_reg.ctrl & ~wmask) | wdat;
            end
            pin_group_pkg::OFF_WRCFG: begin
               // Atomic update of selected pins in this one cycle
               for (int i = 0; i < pin_group_pkg::PIN_COUNT; i++) begin
                  if (pin_sel[i] && dat_i[pin_group_pkg::WC_UPD_CFG])
                  begin
                     state_next.fen[i]  = dat_i[pin_group_pkg::WC_FEN];
                     state_next.input_buffer_on[i] = dat_i[pin_group_pkg::WC_INPUT_BUFFER_ON];
                     state_next.pull[i] = dat_i[pin_group_pkg::WC_PULL];
                     state_next.drv[i]  = dat_i[pin_group_pkg::WC_DRV];
                  end
                  if (pin_sel[i] && dat_i[pin_group_pkg::WC_UPD_FUNC])
                  begin
                     state_next.func[i] =
                        dat_i[pin_group_pkg::WC_FUNC_LSB +: 4];
                  end
               end
            end
            default: begin
               // Per-pin bytes, honouring byte enables
               for (int i = 0; i < pin_group_pkg::PIN_COUNT; i++) begin
                  if (off_word == PCFG_W0 + 5'(i / 4) && sel_i[i%4]) begin
                     state_next.fen[i]  =
                        dat_i[(i%4)*8 + pin_group_pkg::PC_FEN];
                     state_next.input_buffer_on[i] =
                        dat_i[(i%4)*8 + pin_group_pkg::PC_INPUT_BUFFER_ON];
                     state_next.pull[i] =
                        dat_i[(i%4)*8 + pin_group_pkg::PC_PULL];
                     state_next.drv[i]  =
                        dat_i[(i%4)*8 + pin_group_pkg::PC_DRV];
                  end
                  if (off_word == FUNCTION_SELECT_W0 + 5'(i / 8)
                      && sel_i[(i%8)/2]) begin
                     state_next.func[i] = dat_i[(i%8)*4 +: 4];
                  end
               end
            end
         endcase
      end
      // Lane enables follow the current sampling and direction
      state_next.lane = lane_req(state_reg.ctrl, state_reg.dir);
      // Route only enabled pins with a legal function code
      for (int i = 0; i < pin_group_pkg::PIN_COUNT; i++) begin
         state_next.act[i] = state_reg.fen[i]
            && (state_reg.func[i] <= pin_group_pkg::FUNC_LAST);
      end
   end

   // State register with synchronous reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg      <= '0;
         state_reg.dir  <= pin_group_pkg::DIR_RST;
         state_reg.ctrl <= pin_group_pkg::CTRL_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from the state register
   assign dat_o       = state_reg.rdata;
   assign ack_o       = state_reg.ack;
   assign dir_o       = state_reg.dir;
   assign lane_cont_o = state_reg.lane;
   assign fen_o       = state_reg.fen;
   assign input_buffer_on_o      = state_reg.input_buffer_on;
   assign pull_o      = state_reg.pull;
   assign drv_o       = state_reg.drv;
   assign func_o      = state_reg.func;
   assign func_act_o  = state_reg.act;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   direction_set_or_a: assert property (hit && we_i && grp_ok
      && off == pin_group_pkg::OFF_DIRECTION_SET
      |=> dir_o == ($past(dir_o) | $past(wdat)))
      else $error("direction set did not OR in written ones");

   dir_views_a: assert property (hit && !we_i && grp_ok
      && off == pin_group_pkg::OFF_DIRECTION_TOGGLE |=> dat_o == $past(dir_o))
      else $error("toggle view differs from direction");

   group_miss_a: assert property (hit && !grp_ok
      |=> $stable(dir_o) && $stable(func_o) && dat_o == 32'h0)
      else $error("foreign group access changed state");

   lane_follow_a: assert property (##1 lane_cont_o[1]
      == $past(|(state_reg.ctrl[15:8] & ~dir_o[15:8])))
      else $error("lane one sampler enable wrong");

   lane_any_a: assert property (state_reg.ctrl[3] && !dir_o[3]
      ##1 $stable(state_reg.ctrl) && $stable(dir_o) |-> lane_cont_o[0])
      else $error("lane zero not continuous");

   cfg_load_a: assert property (hit && we_i && grp_ok
      && off == pin_group_pkg::OFF_WRCFG && dat_i[30] && !dat_i[31]
      && dat_i[0] |=> pull_o[0] == $past(dat_i[18])
      && drv_o[0] == $past(dat_i[22]) && input_buffer_on_o[0] == $past(dat_i[17]))
      else $error("pin settings not loaded");

   func_load_a: assert property (hit && we_i && grp_ok
      && off == pin_group_pkg::OFF_WRCFG && dat_i[28] && dat_i[31]
      && dat_i[0] |=> func_o[67:64] == $past(dat_i[27:24]))
      else $error("function code not loaded");

   unsel_keep_a: assert property (hit && we_i && grp_ok
      && off == pin_group_pkg::OFF_WRCFG && !dat_i[31] && !dat_i[1]
      |=> $stable(func_o[7:4]) && $stable(pull_o[1]))
      else $error("unselected pin changed");

   wrcfg_zero_a: assert property (hit && !we_i && grp_ok
      && off == pin_group_pkg::OFF_WRCFG |=> ack_o && dat_o == 32'h0)
      else $error("atomic write register read nonzero");

   act_gate_a: assert property (!fen_o[1] || func_o[7:4] > 4'hd
      |=> !func_act_o[1])
      else $error("odd pin routed while disabled");

   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack held more than one cycle");

   // Clear and toggle views act on the same direction state
   direction_clear_and_a: assert property (hit && we_i && grp_ok
      && off == pin_group_pkg::OFF_DIRECTION_CLEAR
      |=> dir_o == ($past(dir_o) & ~$past(wdat)))
      else $error("direction clear did not remove ones");

   direction_toggle_xor_a: assert property (hit && we_i && grp_ok
      && off == pin_group_pkg::OFF_DIRECTION_TOGGLE
      |=> dir_o == ($past(dir_o) ^ $past(wdat)))
      else $error("direction toggle did not flip bits");

   direction_set_zero_a: assert property (hit && we_i && grp_ok
      && off == pin_group_pkg::OFF_DIRECTION_SET
      |=> (dir_o & ~$past(wdat)) == ($past(dir_o) & ~$past(wdat)))
      else $error("direction set changed a zero bit");

   // Atomic write: update bits gate every field
   fen_load_a: assert property (hit && we_i && grp_ok
      && off == pin_group_pkg::OFF_WRCFG && dat_i[30] && dat_i[31]
      && dat_i[15] |=> fen_o[31] == $past(dat_i[16]))
      else $error("function enable not loaded");

   cfg_skip_a: assert property (hit && we_i && grp_ok
      && off == pin_group_pkg::OFF_WRCFG && !dat_i[30]
      |=> $stable(fen_o) && $stable(input_buffer_on_o) && $stable(pull_o)
      && $stable(drv_o))
      else $error("pin settings changed without update bit");

   func_skip_a: assert property (hit && we_i && grp_ok
      && off == pin_group_pkg::OFF_WRCFG && !dat_i[28]
      |=> $stable(func_o))
      else $error("function codes changed without update bit");

   even_code_a: assert property (hit && we_i && grp_ok
      && off == pin_group_pkg::OFF_WRCFG && dat_i[28] && !dat_i[31]
      && dat_i[2] |=> func_o[11:8] == $past(dat_i[27:24]))
      else $error("even pin code not loaded");

   // Bus answer and read views
   ack_next_a: assert property (hit |=> ack_o)
      else $error("access not answered next cycle");

   rdata_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("read data outside an answer");

   function_select_read_a: assert property (hit && !we_i && grp_ok
      && off == pin_group_pkg::OFF_FUNCTION_SELECT |=> dat_o == $past(func_o[31:0]))
      else $error("function pair word differs from codes");

   pcfg_read_a: assert property (hit && !we_i && grp_ok
      && off == pin_group_pkg::OFF_PCFG |=> dat_o[6] == $past(drv_o[0])
      && dat_o[2] == $past(pull_o[0]) && dat_o[1] == $past(input_buffer_on_o[0]))
      else $error("pin settings byte differs from state");

   // Enabled pins with a legal code are routed
   even_gate_a: assert property (fen_o[0] && func_o[3:0] <= 4'hd
      |=> func_act_o[0])
      else $error("enabled even pin not routed");

   odd_route_a: assert property (fen_o[1] && func_o[7:4] <= 4'hd
      |=> func_act_o[1])
      else $error("enabled odd pin with legal code not routed");

endmodule

// [design/pin_group_pkg.sv]
// Purpose: Shared constants for the pin group configuration unit.
// Assumes: One 32-pin group per instance, byte-addressed 32-bit bus.
// Notes:   Offsets are byte offsets inside one group window.
package pin_group_pkg;
   // Group window and pin layout
   localparam int          PIN_COUNT     = 32;     // Pins per group
   localparam int          LANE_PINS     = 8;      // Pins per sampler lane
   localparam int          LANE_COUNT    = 4;      // Sampler lanes
   localparam int          GROUP_SPAN_LG = 7;      // 0x80 byte spacing
   localparam int          OFF_W         = 7;      // Offset width in window
   // Register byte offsets
   localparam logic [6:0]  OFF_DIR       = 7'h00;  // Direction, plain view
   localparam logic [6:0]  OFF_DIRECTION_CLEAR    = 7'h04;  // Direction clear view
   localparam logic [6:0]  OFF_DIRECTION_SET    = 7'h08;  // Direction set view
   localparam logic [6:0]  OFF_DIRECTION_TOGGLE    = 7'h0c;  // Direction toggle view
   localparam logic [6:0]  OFF_CTRL      = 7'h24;  // Sampling mode
   localparam logic [6:0]  OFF_WRCFG     = 7'h28;  // Atomic config write
   localparam logic [6:0]  OFF_FUNCTION_SELECT      = 7'h30;  // Function select pairs
   localparam logic [6:0]  OFF_PCFG      = 7'h40;  // Pin settings bytes
   localparam int          FUNCTION_SELECT_WORDS    = 4;      // Pair words
   localparam int          PCFG_WORDS    = 8;      // Settings words
   // Reset values
   localparam logic [31:0] DIR_RST       = 32'h0000_0000;
   localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
   // Atomic config write fields
   localparam int          WC_MASK_LSB   = 0;      // pin_mask_sel [15:0]
   localparam int          WC_MASK_W     = 16;
   localparam int          WC_FEN        = 16;     // function_select_on
   localparam int          WC_INPUT_BUFFER_ON       = 17;     // input_buffer_on
   localparam int          WC_PULL       = 18;     // pull_resistor_on
   localparam int          WC_DRV        = 22;     // drive_strength
   localparam int          WC_FUNC_LSB   = 24;     // Function code 27:24
   localparam int          WC_UPD_FUNC   = 28;     // update_function_select
   localparam int          WC_UPD_CFG    = 30;     // update_pin_settings
   localparam int          WC_HALF_WORD_SELECT      = 31;     // half_word_select
   // Pin settings byte layout
   localparam int          PC_FEN        = 0;
   localparam int          PC_INPUT_BUFFER_ON       = 1;
   localparam int          PC_PULL       = 2;
   localparam int          PC_DRV        = 6;
   // Function codes
   localparam int          FUNC_W        = 4;
   localparam logic [3:0]  FUNC_LAST     = 4'hd;   // Function N, top legal
endpackage

// [verification/pin_group_tb.sv]
// Purpose: Self-checking bench for the pin group configuration unit.
// Assumes: Group window 0, classic Wishbone, one request at a time.
// Notes:   A bench model of direction, sampling and pin state is compared.
`timescale 1ns/10ps
module testbench;
   logic           clk_i;         // Bus clock, 4 ns period
   logic           rst_i;         // Synchronous reset, active high
   logic           cyc_i;         // Bus cycle
   logic           stb_i;         // Bus strobe
   logic           we_i;          // Write when high
   logic [11:0]    adr_i;         // Byte address
   logic [3:0]     sel_i;         // Byte enables
   logic [31:0]    dat_i;         // Write data
   logic [31:0]    dat_o;         // Read data
   logic           ack_o;         // Bus answer
   logic [31:0]    dir_o;         // Pin direction
   logic [3:0]     lane_cont_o;   // Lane samplers on
   logic [31:0]    fen_o;         // Function enable per pin
   logic [31:0]    input_buffer_on_o;        // Input buffer per pin
   logic [31:0]    pull_o;        // Pull per pin
   logic [31:0]    drv_o;         // Drive strength per pin
   logic [127:0]   func_o;        // Function code per pin
   logic [31:0]    func_act_o;    // Peripheral routed per pin
   int             errors;        // Mismatch count
   int             total_checks;  // Comparison count
   int             seed;          // Random seed
   logic [31:0]    m_dir;         // Model direction
   logic [31:0]    m_samp;        // Model sampling mode
   logic [31:0]    m_fen;         // Model function enable
   logic [31:0]    m_input_buffer_on;        // Model input buffer
   logic [31:0]    m_pull;        // Model pull
   logic [31:0]    m_drv;         // Model drive strength
   logic [3:0]     m_func [32];   // Model function codes
   logic [31:0]    rd;            // Scratch read data

   pin_group_config_unit #(.ADR_W(12), .GROUP_INDEX(0)) DUT (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .dir_o(dir_o),
      .lane_cont_o(lane_cont_o), .fen_o(fen_o), .input_buffer_on_o(input_buffer_on_o),
      .pull_o(pull_o), .drv_o(drv_o), .func_o(func_o),
      .func_act_o(func_act_o));

   // Free-running clock
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   // Print counts and the verdict, then end the run
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // One comparison, counted
   task automatic check(input logic [127:0] got, input logic [127:0] exp,
                        input string what);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t %s mismatch", $time, what);
      end
   endtask

   // One classic bus cycle; holds the request until ack is sampled
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      sel_i <= 4'hf;
      dat_i <= d;
      // Wait for the answer; only the watchdog ends a hang
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
   endtask

   // Read and compare one register
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      check(128'(q), 128'(exp), "read");
   endtask

   // Compare every pin output with the model once the state has settled
   task automatic outs_chk();
      logic [127:0] ef;
      logic [31:0]  ea;
      logic [3:0]   el;
      repeat (2) @(posedge clk_i);
      for (int i = 0; i < 32; i++) begin
         ef[4*i +: 4] = m_func[i];
         ea[i] = m_fen[i] && (m_func[i] <= 4'hd);
      end
      for (int l = 0; l < 4; l++) begin
         el[l] = |(m_samp[8*l +: 8] & ~m_dir[8*l +: 8]);
      end
      check(128'(dir_o), 128'(m_dir), "direction");
      check(128'(lane_cont_o), 128'(el), "lane sampler");
      check(128'(fen_o), 128'(m_fen), "function enable");
      check(128'({input_buffer_on_o, pull_o, drv_o}),
            128'({m_input_buffer_on, m_pull, m_drv}), "cfg");
      check(func_o, ef, "function code");
      check(128'(func_act_o), 128'(ea), "function routed");
   endtask

   // Reset the design and the model together
   task automatic do_reset();
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      {m_dir, m_samp, m_fen, m_input_buffer_on, m_pull, m_drv} = '0;
      for (int i = 0; i < 32; i++) m_func[i] = 4'h0;
   endtask

   // Main sequence
   initial begin
      logic [31:0] d;
      int          p;
      seed = 38259;
      errors = 0;
      total_checks = 0;
      {rst_i, cyc_i, stb_i, we_i} = 4'h8;
      adr_i = 12'h000;
      sel_i = 4'hf;
      dat_i = 32'h0000_0000;
      do_reset();
      outs_chk();
      rd_chk(12'h000, 32'h0000_0000);
      rd_chk(12'h024, 32'h0000_0000);
      $display("test reset done");
      // Sparse set writes, a zero write first; all four views agree
      for (int k = 0; k < 8; k++) begin
         d = (k == 0) ? 32'h0 : $random(seed) & $random(seed);
         bus(1'b1, 12'h008, d, rd);
         m_dir = m_dir | d;
         outs_chk();
         for (int v = 0; v < 4; v++) rd_chk(12'(4 * v), m_dir);
      end
      // Clear and toggle views act on the same state
      bus(1'b1, 12'h004, 32'h0f0f_0f0f, rd);
      m_dir = m_dir & ~32'h0f0f_0f0f;
      bus(1'b1, 12'h00c, 32'h00ff_ff00, rd);
      m_dir = m_dir ^ 32'h00ff_ff00;
      outs_chk();
      rd_chk(12'h008, m_dir);
      $display("test direction done");
      // Lane boundary cases, then random modes
      do_reset();
      bus(1'b1, 12'h008, 32'h00ff_0100, rd);
      m_dir = 32'h00ff_0100;
      for (int k = 0; k < 6; k++) begin
         d = (k == 0) ? 32'h0000_0100 : (k == 1) ? 32'h0000_0200
                                                 : $random(seed);
         bus(1'b1, 12'h024, d, rd);
         m_samp = d;
         outs_chk();
         rd_chk(12'h024, d);
      end
      $display("test sampling done");
      // Atomic writes with every code, both halves, both update bits
      for (int k = 0; k < 40; k++) begin
         d = $random(seed);
         d[27:24] = 4'(k);
         bus(1'b1, 12'h028, d, rd);
         for (int i = 0; i < 16; i++) begin
            p = d[31] ? 16 + i : i;
            if (d[i] && d[30]) begin
               {m_fen[p], m_input_buffer_on[p], m_pull[p], m_drv[p]} =
                  {d[16], d[17], d[18], d[22]};
            end
            if (d[i] && d[28]) m_func[p] = d[27:24];
         end
         outs_chk();
         rd_chk(12'h028, 32'h0000_0000);
      end
      $display("test atomic done");
      // Pin settings bytes and function pair words read back
      for (int w = 0; w < 8; w++) begin
         for (int b = 0; b < 4; b++) begin
            d[8*b +: 8] = {1'b0, m_drv[4*w+b], 3'b000, m_pull[4*w+b],
                           m_input_buffer_on[4*w+b], m_fen[4*w+b]};
         end
         rd_chk(12'h040 + 12'(4 * w), d);
      end
      for (int w = 0; w < 4; w++) begin
         for (int b = 0; b < 8; b++) begin
            d[4*b +: 4] = m_func[8*w+b];
         end
         rd_chk(12'h030 + 12'(4 * w), d);
      end
      $display("test views done");
      // Writes outside the window leave the group alone
      bus(1'b1, 12'h088, 32'hffff_ffff, rd);
      bus(1'b1, 12'h0a8, 32'hd1ff_ffff, rd);
      outs_chk();
      rd_chk(12'h080, 32'h0000_0000);
      rd_chk(12'h07c, 32'h0000_0000);
      $display("test window done");
      stop_test();
   end

   // Hang guard, far beyond the expected run length
   initial begin
      #200000;
      errors++;
      $display("[ERR] %0t watchdog expired", $time);
      stop_test();
   end
endmodule
